// ===== src/modulation_part_select.sv
// modulation share of a power limit or of an update step
`timescale 1ns/1ps
module modulation_part_select (
  // selection
  input  wire tx_power_limit_pkg::mod_class_t           modulation,
  input  wire logic [tx_power_limit_pkg::LEVEL_W-1:0]   topLevel,
  input  wire logic [tx_power_limit_pkg::LEVEL_W-1:0]   modDec,
  // result
  output logic      [tx_power_limit_pkg::LEVEL_W-1:0]   part
);
  import tx_power_limit_pkg::*;

  // ----------------------------------------------------------------
  // ordered classes, each no higher than the one above
  // ----------------------------------------------------------------
  logic [LEVEL_W-1:0] part16;  // 16QAM share
  logic [LEVEL_W-1:0] partQ;   // QPSK share

  always_comb begin
    part16 = sat_sub(topLevel, modDec);
    partQ  = sat_sub(part16, modDec);
    case (modulation)
      MOD_64QAM: part = topLevel;
      MOD_16QAM: part = part16;
      MOD_QPSK:  part = partQ;
      default:   part = partQ;           // spare code taken as lowest class
    endcase
  end

endmodule

// ===== src/neighbour_part_select.sv
// neighbour share of a power limit or of an update step
`timescale 1ns/1ps
module neighbour_part_select (
  // occupancy
  input  wire tx_power_limit_pkg::occupancy_t           adjChannel,
  input  wire tx_power_limit_pkg::occupancy_t           adjCell,
  // levels
  input  wire logic [tx_power_limit_pkg::LEVEL_W-1:0]   maxLevel,
  input  wire logic [tx_power_limit_pkg::LEVEL_W-1:0]   incumbentLevel,
  input  wire logic [tx_power_limit_pkg::LEVEL_W-1:0]   modTop,
  input  wire logic [tx_power_limit_pkg::LEVEL_W-1:0]   nbrDec,
  // result
  output logic      [tx_power_limit_pkg::LEVEL_W-1:0]   part
);
  import tx_power_limit_pkg::*;

  // ----------------------------------------------------------------
  // table of neighbour shares
  // ----------------------------------------------------------------
  logic               chanBusy;   // adjacent channel unlicensed/unknown
  logic               cellBusy;   // adjacent cell unlicensed/unknown
  logic [LEVEL_W-1:0] freeLvl;    // nothing heard anywhere
  logic [LEVEL_W-1:0] incLvl;     // incumbent next door
  logic [LEVEL_W-1:0] oneSide;    // one side unlicensed
  logic [LEVEL_W-1:0] incCell;    // incumbent plus unlicensed cell
  logic [LEVEL_W-1:0] bothSide;   // both sides unlicensed

  always_comb begin
    // incumbent in the adjacent cell is ignored and counts as a free cell
    chanBusy = (adjChannel == OCC_UNLIC) || (adjChannel == OCC_UNKNOWN);
    cellBusy = (adjCell == OCC_UNLIC) || (adjCell == OCC_UNKNOWN);
    freeLvl  = sat_sub(maxLevel, modTop);
    incLvl   = min_level(sat_sub(incumbentLevel, modTop), freeLvl);
    oneSide  = max_level(sat_sub(freeLvl, nbrDec), incLvl);
    incCell  = sat_sub(incLvl, nbrDec);
    bothSide = max_level(sat_sub(oneSide, nbrDec), incCell);
    if (adjChannel == OCC_INCUMBENT) begin
      part = cellBusy ? incCell : incLvl;
    end else if (chanBusy && cellBusy) begin
      part = bothSide;
    end else if (chanBusy || cellBusy) begin
      part = oneSide;
    end else begin
      part = freeLvl;
    end
  end

endmodule

// ===== src/tx_power_limit_pkg.sv
// shared types, register map and limit constants of the transmit power limit block
package tx_power_limit_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          SEL_W         = 4;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;  // link state, read/write
  localparam logic [7:0]  ADDR_PWR_CFG  = 8'h04;  // initial power tuning, read/write
  localparam logic [7:0]  ADDR_STEP_CFG = 8'h08;  // update step tuning, read/write
  localparam logic [7:0]  ADDR_PWR_STAT = 8'h0C;  // initial power result, read only
  localparam logic [7:0]  ADDR_STEP_STAT = 8'h10; // update step result, read only
  localparam logic [7:0]  ADDR_COUNT    = 8'h14;  // limit change counter, read only

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int CTRL_W   = 7;   // width of the link state word
  localparam int LEVEL_W  = 8;   // power in mW, step in half-dB units
  localparam int CFG_W    = 24;  // width of a tuning word
  localparam int PART_NBR_LSB = 8;   // neighbour part in status words
  localparam int PART_MOD_LSB = 16;  // modulation part in status words
  localparam int COUNT_W  = 16;

  // occupancy class of a neighbouring channel or cell
  typedef enum logic [1:0] {
    OCC_NONE      = 2'b00,
    OCC_UNLIC     = 2'b01,
    OCC_INCUMBENT = 2'b10,
    OCC_UNKNOWN   = 2'b11
  } occupancy_t;

  // modulation class, highest order first
  typedef enum logic [1:0] {
    MOD_64QAM = 2'b00,
    MOD_16QAM = 2'b01,
    MOD_QPSK  = 2'b10,
    MOD_SPARE = 2'b11
  } mod_class_t;

  // link state word as written by software
  typedef struct packed {
    occupancy_t adjChannel;
    occupancy_t adjCell;
    mod_class_t modulation;
    logic       sensingOnly;
  } link_state_t;

  // tuning word: modulation share at 64QAM, and the two decrements
  typedef struct packed {
    logic [LEVEL_W-1:0] modTop;
    logic [LEVEL_W-1:0] modDec;
    logic [LEVEL_W-1:0] nbrDec;
  } limit_cfg_t;

  // ----------------------------------------------------------------
  // limits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PWR_MAX_DB      = 8'h64;  // 100 mW
  localparam logic [7:0] PWR_MAX_SENSE   = 8'h32;  // 50 mW
  localparam logic [7:0] PWR_INCUMB_CAP  = 8'h28;  // 40 mW
  localparam logic [7:0] STEP_MAX_DB     = 8'h04;  // 2 dB in half-dB units
  localparam logic [7:0] STEP_MAX_SENSE  = 8'h02;  // 1 dB in half-dB units
  localparam link_state_t CTRL_RST       = '{OCC_NONE, OCC_NONE, MOD_QPSK, 1'b1};
  localparam limit_cfg_t  PWR_CFG_RST    = '{8'h14, 8'h05, 8'h0A};
  localparam limit_cfg_t  STEP_CFG_RST   = '{8'h02, 8'h01, 8'h01};

  // subtract without wrapping below zero
  function automatic logic [LEVEL_W-1:0] sat_sub(input logic [LEVEL_W-1:0] a,
                                                 input logic [LEVEL_W-1:0] b);
    sat_sub = (a > b) ? a - b : '0;
  endfunction

  // smaller of two levels
  function automatic logic [LEVEL_W-1:0] min_level(input logic [LEVEL_W-1:0] a,
                                                   input logic [LEVEL_W-1:0] b);
    min_level = (a < b) ? a : b;
  endfunction

  // larger of two levels
  function automatic logic [LEVEL_W-1:0] max_level(input logic [LEVEL_W-1:0] a,
                                                   input logic [LEVEL_W-1:0] b);
    max_level = (a > b) ? a : b;
  endfunction

endpackage

// ===== src/tx_power_limit_select.sv
// transmit power limit selection with a classic Wishbone register slave
`timescale 1ns/1ps

// Summary of operation
// - initial power is neighbour plus modulation share
// - neighbour share follows adjacent channel and cell
// - free neighbourhood: maximum minus 64QAM share
// - busy neighbours lower the share stepwise
// - sensing-only class selects lower value set
// - incumbent in adjacent cell is ignored
// - incumbent adjacent channel caps power at 40 mW
// - mixed occupancy stays between the bounding limits
// - modulation falls into three ordered classes
// - 64QAM share at most 100/50, ordered below
// - free neighbourhood allows 100 mW for database class
// - sensing-only power never above 50 mW
// - update step is neighbour plus modulation step
// - update step at most 2 dB, 1 dB
module tx_power_limit_select (
  // clock and reset
  input  wire logic                                      clk,
  input  wire logic                                      reset_n,
  // wishbone slave
  input  wire logic                                      wb_cyc_i,
  input  wire logic                                      wb_stb_i,
  input  wire logic                                      wb_we_i,
  input  wire logic [tx_power_limit_pkg::ADDR_W-1:0]     wb_adr_i,
  input  wire logic [tx_power_limit_pkg::SEL_W-1:0]      wb_sel_i,
  input  wire logic [tx_power_limit_pkg::DATA_W-1:0]     wb_dat_i,
  output logic      [tx_power_limit_pkg::DATA_W-1:0]     wb_dat_o,
  output logic                                           wb_ack_o,
  // selected limits
  output logic      [tx_power_limit_pkg::LEVEL_W-1:0]    powerLimit,
  output logic      [tx_power_limit_pkg::LEVEL_W-1:0]    stepLimit,
  output logic                                           limitUpdated
);
  import tx_power_limit_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  link_state_t        linkState;     // occupancy, modulation, class
  limit_cfg_t         pwrCfg;        // initial power tuning
  limit_cfg_t         stepCfg;       // update step tuning
  logic               busReq;        // new access this cycle
  logic               busWrite;      // new write this cycle
  logic [LEVEL_W-1:0] pwrMax;        // class ceiling, mW
  logic [LEVEL_W-1:0] stepMax;       // class ceiling, half dB
  logic [LEVEL_W-1:0] pwrIncCap;     // incumbent ceiling, mW
  logic [LEVEL_W-1:0] pwrModTop;     // 64QAM share, mW
  logic [LEVEL_W-1:0] stepModTop;    // 64QAM step share
  logic [LEVEL_W-1:0] pwrNbr;        // neighbour share, mW
  logic [LEVEL_W-1:0] pwrMod;        // modulation share, mW
  logic [LEVEL_W-1:0] stepNbr;       // neighbour step share
  logic [LEVEL_W-1:0] stepMod;       // modulation step share
  logic [LEVEL_W:0]   pwrSum;        // wide sum, no wrap
  logic [LEVEL_W:0]   stepSum;       // wide sum, no wrap
  logic [LEVEL_W-1:0] next_power;    // clamped initial power
  logic [LEVEL_W-1:0] next_step;     // clamped update step
  logic [LEVEL_W-1:0] nbrPartReg;    // registered neighbour share
  logic [LEVEL_W-1:0] modPartReg;    // registered modulation share
  logic [LEVEL_W-1:0] nbrStepReg;    // registered neighbour step
  logic [LEVEL_W-1:0] modStepReg;    // registered modulation step
  logic [COUNT_W-1:0] changeCount;   // number of limit changes
  logic [DATA_W-1:0]  next_rdata;    // read mux

  // byte-lane merge of a tuning word
  function automatic limit_cfg_t merge_cfg(input limit_cfg_t old,
                                           input logic [DATA_W-1:0] data,
                                           input logic [SEL_W-1:0] sel);
    logic [CFG_W-1:0] word;
    word = old;
    for (int i = 0; i < CFG_W / 8; i++) begin
      if (sel[i]) begin
        word[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge_cfg = limit_cfg_t'(word);
  endfunction

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // a request counts once; ack drops the cycle after it was given
  always_comb begin
    busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    busWrite = busReq && wb_we_i;
  end

  // ack one cycle after the request, every address answered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq;
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  // link state word, low byte lane only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linkState <= CTRL_RST;
    end else if (busWrite && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
      linkState <= link_state_t'(wb_dat_i[CTRL_W-1:0]);
    end
  end

  // tuning words with fixed defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwrCfg  <= PWR_CFG_RST;
      stepCfg <= STEP_CFG_RST;
    end else if (busWrite) begin
      if (wb_adr_i == ADDR_PWR_CFG) begin
        pwrCfg <= merge_cfg(pwrCfg, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == ADDR_STEP_CFG) begin
        stepCfg <= merge_cfg(stepCfg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // ----------------------------------------------------------------
  // class dependent value sets
  // ----------------------------------------------------------------
  // sensing-only class halves the 64QAM shares and the class ceilings
  always_comb begin
    if (linkState.sensingOnly) begin
      pwrMax     = PWR_MAX_SENSE;
      stepMax    = STEP_MAX_SENSE;
      pwrModTop  = min_level(pwrCfg.modTop >> 1, PWR_MAX_SENSE);
      stepModTop = min_level(stepCfg.modTop >> 1, STEP_MAX_SENSE);
    end else begin
      pwrMax     = PWR_MAX_DB;
      stepMax    = STEP_MAX_DB;
      pwrModTop  = min_level(pwrCfg.modTop, PWR_MAX_DB);
      stepModTop = min_level(stepCfg.modTop, STEP_MAX_DB);
    end
    pwrIncCap = min_level(PWR_INCUMB_CAP, pwrMax);
  end

  // ----------------------------------------------------------------
  // initial power shares
  // ----------------------------------------------------------------
  // neighbour share of the initial power
  neighbour_part_select u_pwr_nbr (
    .adjChannel     (linkState.adjChannel),
    .adjCell        (linkState.adjCell),
    .maxLevel       (pwrMax),
    .incumbentLevel (pwrIncCap),
    .modTop         (pwrModTop),
    .nbrDec         (pwrCfg.nbrDec),
    .part           (pwrNbr)
  );

  // modulation share of the initial power
  modulation_part_select u_pwr_mod (
    .modulation (linkState.modulation),
    .topLevel   (pwrModTop),
    .modDec     (pwrCfg.modDec),
    .part       (pwrMod)
  );

  // ----------------------------------------------------------------
  // update step shares
  // ----------------------------------------------------------------
  // neighbour share of the step, incumbent floor one decrement down
  neighbour_part_select u_step_nbr (
    .adjChannel     (linkState.adjChannel),
    .adjCell        (linkState.adjCell),
    .maxLevel       (stepMax),
    .incumbentLevel (sat_sub(stepMax, stepCfg.nbrDec)),
    .modTop         (stepModTop),
    .nbrDec         (stepCfg.nbrDec),
    .part           (stepNbr)
  );

  // modulation share of the step
  modulation_part_select u_step_mod (
    .modulation (linkState.modulation),
    .topLevel   (stepModTop),
    .modDec     (stepCfg.modDec),
    .part       (stepMod)
  );

  // ----------------------------------------------------------------
  // sums and ceilings
  // ----------------------------------------------------------------
  // sum the shares, then clip both to class ceilings and the power also to the incumbent ceiling when the adjacent channel is incumbent
  always_comb begin
    pwrSum  = {1'b0, pwrNbr} + {1'b0, pwrMod};
    stepSum = {1'b0, stepNbr} + {1'b0, stepMod};
    if (pwrSum > {1'b0, pwrMax}) begin
      next_power = pwrMax;
    end else begin
      next_power = pwrSum[LEVEL_W-1:0];
    end
    if (linkState.adjChannel == OCC_INCUMBENT) begin
      next_power = min_level(next_power, pwrIncCap);
    end
    if (stepSum > {1'b0, stepMax}) begin
      next_step = stepMax;
    end else begin
      next_step = stepSum[LEVEL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // registered results
  // ----------------------------------------------------------------
  // limits follow input changes on the next edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      powerLimit <= '0;
      stepLimit  <= '0;
    end else begin
      powerLimit <= next_power;
      stepLimit  <= next_step;
    end
  end

  // shares kept for software readback
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nbrPartReg <= '0;
      modPartReg <= '0;
      nbrStepReg <= '0;
      modStepReg <= '0;
    end else begin
      nbrPartReg <= pwrNbr;
      modPartReg <= pwrMod;
      nbrStepReg <= stepNbr;
      modStepReg <= stepMod;
    end
  end

  // one-cycle pulse and count when either limit moves
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      limitUpdated <= 1'b0;
      changeCount  <= '0;
    end else if (next_power != powerLimit || next_step != stepLimit) begin
      limitUpdated <= 1'b1;
      changeCount  <= changeCount + 1'b1;
    end else begin
      limitUpdated <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read mux, unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    case (wb_adr_i)
      ADDR_CTRL:      next_rdata[CTRL_W-1:0] = linkState;
      ADDR_PWR_CFG:   next_rdata[CFG_W-1:0]  = pwrCfg;
      ADDR_STEP_CFG:  next_rdata[CFG_W-1:0]  = stepCfg;
      ADDR_PWR_STAT: begin
        next_rdata[LEVEL_W-1:0]                  = powerLimit;
        next_rdata[PART_NBR_LSB +: LEVEL_W]      = nbrPartReg;
        next_rdata[PART_MOD_LSB +: LEVEL_W]      = modPartReg;
      end
      ADDR_STEP_STAT: begin
        next_rdata[LEVEL_W-1:0]                  = stepLimit;
        next_rdata[PART_NBR_LSB +: LEVEL_W]      = nbrStepReg;
        next_rdata[PART_MOD_LSB +: LEVEL_W]      = modStepReg;
      end
      ADDR_COUNT:     next_rdata[COUNT_W-1:0] = changeCount;
      default:        next_rdata = '0;
    endcase
  end

  // read data registered with the ack
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= '0;
    end else if (busReq && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end else begin
      wb_dat_o <= '0;
    end
  end

endmodule

// ===== tb/link_state_source.sv
// occupancy and modulation report source standing in for sensing or database lookup
`timescale 1ns/1ps
module link_state_source (
  // scenario selection
  input  wire logic [6:0]                index,
  // report
  output tx_power_limit_pkg::link_state_t report
);
  import tx_power_limit_pkg::*;
  // every occupancy and modulation code, cell incumbents included
  assign report = link_state_t'(index);
endmodule

// ===== tb/tx_power_limit_select_props.sv
// assertion checker for the transmit power limit block
`timescale 1ns/1ps
module tx_power_limit_select_props (
  // clock and reset
  input wire logic                                   clk,
  input wire logic                                   reset_n,
  // bus
  input wire logic                                   wb_cyc_i,
  input wire logic                                   wb_stb_i,
  input wire logic                                   wb_we_i,
  input wire logic [tx_power_limit_pkg::ADDR_W-1:0]  wb_adr_i,
  input wire logic [tx_power_limit_pkg::SEL_W-1:0]   wb_sel_i,
  input wire logic [tx_power_limit_pkg::DATA_W-1:0]  wb_dat_i,
  input wire logic [tx_power_limit_pkg::DATA_W-1:0]  wb_dat_o,
  input wire logic                                   wb_ack_o,
  // limits
  input wire logic [tx_power_limit_pkg::LEVEL_W-1:0] powerLimit,
  input wire logic [tx_power_limit_pkg::LEVEL_W-1:0] stepLimit,
  input wire logic                                   limitUpdated
);
  import tx_power_limit_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic        take;     // request taken at this edge
  logic        ctrlWr;   // control word written at this edge
  link_state_t ctrlSeen; // last control word committed
  assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctrlWr = take && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0];
  // mirror of the control word, same edge as the design
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlSeen <= CTRL_RST;
    end else if (ctrlWr) begin
      ctrlSeen <= link_state_t'(wb_dat_i[CTRL_W-1:0]);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_ack_next; take |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == '0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_upd; ($changed(powerLimit) || $changed(stepLimit)) == limitUpdated; endproperty
  a_upd: assert property (p_upd) else $error("update pulse mismatch");
  property p_sense_cap;
    $past(ctrlSeen.sensingOnly) |-> powerLimit <= PWR_MAX_SENSE && stepLimit <= STEP_MAX_SENSE;
  endproperty
  a_sense_cap: assert property (p_sense_cap) else $error("sensing cap broken");
  property p_inc_cap; $past(ctrlSeen.adjChannel) == OCC_INCUMBENT |-> powerLimit <= PWR_INCUMB_CAP;
  endproperty
  a_inc_cap: assert property (p_inc_cap) else $error("incumbent cap broken");
  property p_max; powerLimit <= PWR_MAX_DB && stepLimit <= STEP_MAX_DB; endproperty
  a_max: assert property (p_max) else $error("limit above maximum");
  property p_free;
    ctrlWr && wb_dat_i[CTRL_W-1:0] == '0 |->
      ##2 powerLimit == PWR_MAX_DB && stepLimit == STEP_MAX_DB;
  endproperty
  a_free: assert property (p_free) else $error("free limits wrong");
  // main scenarios reached
  c_write: cover property (ctrlWr);
  c_upd: cover property (limitUpdated);
  c_inc: cover property (ctrlSeen.adjChannel == OCC_INCUMBENT);
endmodule
bind tx_power_limit_select tx_power_limit_select_props u_props (.clk, .reset_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .powerLimit,
  .stepLimit, .limitUpdated);

// ===== tb/tx_power_limit_select_test.sv
// self-checking bench of the transmit power limit block
`timescale 1ns/1ps
module tx_power_limit_select_test;
  import tx_power_limit_pkg::*;
  logic clk = 1'b0, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, limitUpdated;
  logic [7:0]  wb_adr_i, powerLimit, stepLimit;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [31:0] cnt;          // change counter seen before a known change
  logic [6:0]  idx;          // report selector for the source model
  link_state_t rep;          // report of the source model
  int          numErrors = 0;
  int          nTests = 0;
  always #25 clk = ~clk;
  tx_power_limit_select u_dut (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .powerLimit, .stepLimit, .limitUpdated);
  link_state_source u_src (.index(idx), .report(rep));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nTests++;
    if (seen !== want) begin
      numErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict;
    if (numErrors == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one classic cycle, bounded wait for ack
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin numErrors++; give_verdict(); end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    @(posedge clk);
  endtask
  // expected power from occupancy, class and the 64QAM share
  function automatic logic [7:0] exp_pwr(input link_state_t s, input int top);
    int mx, mt, fr, inc, one, nbr, tot;
    occupancy_t ch, ce;
    mx = s.sensingOnly ? 50 : 100;
    mt = s.sensingOnly ? top / 2 : top;
    ch = (s.adjChannel == OCC_UNKNOWN) ? OCC_UNLIC : s.adjChannel;
    ce = (s.adjCell == OCC_UNKNOWN) ? OCC_UNLIC :
         (s.adjCell == OCC_INCUMBENT) ? OCC_NONE : s.adjCell;
    fr = mx - mt;
    inc = (40 - mt < fr) ? 40 - mt : fr;
    one = (fr - 10 > inc) ? fr - 10 : inc;
    if (ch == OCC_INCUMBENT) nbr = (ce == OCC_NONE) ? inc : inc - 10;
    else if (ch == OCC_UNLIC && ce == OCC_UNLIC) nbr = (one - 10 > inc - 10) ? one - 10 : inc - 10;
    else if (ch == OCC_NONE && ce == OCC_NONE) nbr = fr;
    else nbr = one;
    tot = nbr + mt - 5 * ((s.modulation == MOD_SPARE) ? 2 : int'(s.modulation));
    if (tot > mx) tot = mx;
    if (ch == OCC_INCUMBENT && tot > 40) tot = 40;
    return tot[7:0];
  endfunction
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0; idx = 7'h00;
    repeat (3) @(posedge clk);
    check(powerLimit, 32'h0);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(powerLimit, exp_pwr(CTRL_RST, 20));
    xfer(ADDR_CTRL, 1'b0, 32'h0); check(q, 32'h05);
    xfer(ADDR_PWR_CFG, 1'b0, 32'h0); check(q, 32'h0014050A);
    xfer(ADDR_STEP_CFG, 1'b0, 32'h0); check(q, 32'h00020101);
    xfer(8'h20, 1'b1, 32'hFFFFFFFF); xfer(8'h20, 1'b0, 32'h0); check(q, 32'h0);
    // every occupancy, modulation and class combination
    for (int i = 0; i < 128; i++) begin
      idx <= i[6:0];
      @(posedge clk);
      xfer(ADDR_CTRL, 1'b1, {25'h0, rep});
      check(powerLimit, exp_pwr(rep, 20));
      if (rep[6:1] == 6'h00) check(stepLimit, rep[0] ? 8'h02 : 8'h04);
    end
    // status word is read only
    xfer(ADDR_PWR_STAT, 1'b1, 32'h0); xfer(ADDR_PWR_STAT, 1'b0, 32'h0);
    check(q[7:0], exp_pwr(rep, 20));
    // larger 64QAM share changes the split, not the caps
    xfer(ADDR_PWR_CFG, 1'b1, 32'h001E050A);
    for (int k = 0; k < 4; k++) begin
      idx <= (k == 0) ? 7'h00 : (k == 1) ? 7'h40 : (k == 2) ? 7'h28 : 7'h0D;
      @(posedge clk);
      xfer(ADDR_CTRL, 1'b1, {25'h0, rep});
      check(powerLimit, exp_pwr(rep, 30));
    end
    // one limit change bumps the counter once; full status words
    xfer(ADDR_COUNT, 1'b0, 32'h0);
    cnt = q;
    xfer(ADDR_CTRL, 1'b1, 32'h0);
    xfer(ADDR_COUNT, 1'b0, 32'h0);
    check(q, cnt + 32'h1);
    xfer(ADDR_PWR_STAT, 1'b0, 32'h0);
    check(q, 32'h001E4664);
    xfer(ADDR_STEP_STAT, 1'b0, 32'h0);
    check(q, 32'h00020204);
    give_verdict();
  end
endmodule
